// [core/spr_clk_ctl.sv]
// Suspend clock stop and clock settle sequencer
`timescale 1ns/100ps
module spr_clk_ctl
  import spr_pkg::*;
#(
  parameter int P_CNT_W = 20
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_suspend,
  input wire logic i_keep_on,
  input wire logic [P_CNT_W-1:0] i_settle_cyc,
  output logic o_clk_run,
  output logic o_stable
);

  initial begin
    if (P_CNT_W < 2 || P_CNT_W > 31) begin
      $error("P_CNT_W out of range");
    end
  end

  spr_ck_e state_ff;
  logic [P_CNT_W-1:0] cnt_ff;

  // ********************************************************
  // Clock state machine
  // ********************************************************
  // Stopping only when software allowed it; waking always passes the settle wait
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_ff <= CK_RUN;
    end else begin
      unique case (state_ff)
        CK_RUN: begin
          if (i_suspend && !i_keep_on) begin
            state_ff <= CK_STOP;
          end
        end
        CK_STOP: begin
          if (!i_suspend || i_keep_on) begin
            state_ff <= CK_SETTLE;
          end
        end
        CK_SETTLE: begin
          if (cnt_ff == '0) begin
            state_ff <= CK_RUN;
          end
        end
      endcase
    end
  end

  // Settle counter loads on the stop state, counts down while settling
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      cnt_ff <= '0;
    end else if (state_ff == CK_STOP) begin
      cnt_ff <= i_settle_cyc - 1'b1;
    end else if (state_ff == CK_SETTLE && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // Event fires once clocks ran the whole settle time
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_stable <= 1'b0;
    end else begin
      o_stable <= (state_ff == CK_SETTLE) && (cnt_ff == '0);
    end
  end

  // Clocks stay gated only in the stop state; they run again while settling
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_clk_run <= 1'b1;
    end else begin
      o_clk_run <= !(state_ff == CK_RUN && i_suspend && !i_keep_on)
        && !(state_ff == CK_STOP && i_suspend && !i_keep_on);
    end
  end

endmodule

// [core/spr_pkg.sv]
// Shared constants, types and state codes of the suspend power and port 1 register bank
package spr_pkg;

  // ********************************************************
  // Bus and register map
  // ********************************************************
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFS_PWR = 10'h354;
  localparam logic [9:0] OFS_PORT1 = 10'h374;
  localparam logic [9:0] OFS_IRQ_STAT = 10'h380;
  localparam logic [9:0] OFS_IRQ_MASK = 10'h384;

  // ********************************************************
  // Power-down control fields
  // ********************************************************
  localparam int PWR_KEEP_ON_BIT = 0;
  localparam int PWR_OC1_OFF_BIT = 1;
  localparam int PWR_OC2_OFF_BIT = 2;
  localparam int PWR_WAKE_LSB = 16;
  localparam logic [15:0] WAKE_RST_16 = 16'h17e8;
  localparam logic [15:0] WAKE_FIXED_16 = 16'h1400;
  localparam logic [15:0] WAKE_RST_32 = 16'h0001;

  // ********************************************************
  // Port 1 control fields
  // ********************************************************
  localparam int P1_INIT_CLR_BIT = 23;
  localparam int P1_INIT_FLAG_BIT = 7;
  localparam int P1_PWR_LSB = 3;
  localparam logic [1:0] P1_PWR_ON = 2'b11;
  localparam logic [15:0] P1_RST = 16'h0096;
  localparam logic [15:0] P1_WMASK = 16'hff7f;

  // ********************************************************
  // Interrupt status bits
  // ********************************************************
  localparam int IRQ_W = 3;
  localparam int IRQ_CLK_READY = 0;
  localparam int IRQ_OC1 = 1;
  localparam int IRQ_OC2 = 2;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAKE_T32_NS = 10_000;
  localparam int WAKE_T16_MS = 50;
  localparam int WAKE_CYC_32 = (WAKE_T32_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC_16 = (WAKE_T16_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } spr_avs_req_s;

  typedef struct packed {
    logic [15:0] wake;
    logic oc2_off;
    logic oc1_off;
    logic keep_on;
  } spr_pwr_s;

  typedef enum logic [2:0] {
    CK_RUN = 3'b001,
    CK_STOP = 3'b010,
    CK_SETTLE = 3'b100
  } spr_ck_e;

endpackage

// [core/spr_regs.sv]
// Suspend power-down and port 1 control register bank with Avalon-MM slave
`timescale 1ns/100ps
module spr_regs
  import spr_pkg::*;
#(
  parameter bit P_BUS16 = 1'b0,
  parameter int P_WAKE_CYC_16 = WAKE_CYC_16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_suspend,
  input wire logic i_port1_overcurrent_input_b,
  input wire logic i_port2_overcurrent_input_b,
  output logic o_port1_oc_det_pwr,
  output logic o_port2_oc_det_pwr,
  output logic o_clk_run,
  output logic o_first_port_power_field_on,
  output logic o_port1_init_pending,
  output logic [15:0] o_wake_count,
  output logic o_irq
);

  localparam int CNT_W = 20;
  localparam int SETTLE_LO = WAKE_CYC_32;
  localparam int SETTLE_HI = WAKE_CYC_32 + 4;

  // Settle count must fit the sequencer counter
  initial begin
    if (P_WAKE_CYC_16 < 1 || P_WAKE_CYC_16 >= (1 << CNT_W)) begin
      $error("P_WAKE_CYC_16 out of range");
    end
  end

  // ********************************************************
  // Helpers
  // ********************************************************
  // Byte-lane merge used by the power-down and port 1 registers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ********************************************************
  // Declarations
  // ********************************************************
  spr_avs_req_s req;
  spr_pwr_s pwr_ff;
  logic [15:0] port1_ff;
  logic [IRQ_W-1:0] stat_ff;
  logic [IRQ_W-1:0] mask_ff;
  logic [IRQ_W-1:0] set_ev;
  logic [IRQ_W-1:0] clr_w1c;
  logic wr_acc;
  logic rd_take;
  logic [31:0] pwr_word;
  logic [31:0] pwr_merged;
  logic [31:0] p1_merged;
  logic [1:0] oc_meta_ff;
  logic [1:0] oc_sync_ff;
  logic [1:0] oc_prev_ff;
  logic [1:0] det_on;
  logic clk_run;
  logic clk_stable;
  logic [CNT_W-1:0] settle_cyc;

  // Bus request gathered into one carrier
  assign req = '{rd: i_avs_read, wr: i_avs_write, addr: i_avs_address,
                 wdata: i_avs_writedata, be: i_avs_byteenable};

  // ********************************************************
  // Avalon-MM handshake
  // ********************************************************
  // Waitrequest stays high by default and drops for exactly one cycle per
  // request; a write commits and read data is valid at that same edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((req.rd || req.wr) && o_avs_waitrequest);
    end
  end

  assign wr_acc = req.wr && !o_avs_waitrequest;
  assign rd_take = req.rd && o_avs_waitrequest;
  assign pwr_word = {pwr_ff.wake, 13'h0000, pwr_ff.oc2_off, pwr_ff.oc1_off,
                     pwr_ff.keep_on};
  assign pwr_merged = be_merge(pwr_word, req.wdata, req.be);
  assign p1_merged = be_merge({16'h0000, port1_ff}, req.wdata, req.be);

  // Read data captured one cycle ahead of the acknowledge; unmapped reads zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      unique case (req.addr)
        OFS_PWR: o_avs_readdata <= pwr_word;
        OFS_PORT1: o_avs_readdata <= {port1_ff, port1_ff};
        OFS_IRQ_STAT: o_avs_readdata <= {{(32-IRQ_W){1'b0}}, stat_ff};
        OFS_IRQ_MASK: o_avs_readdata <= {{(32-IRQ_W){1'b0}}, mask_ff};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ********************************************************
  // Power-down control register
  // ********************************************************
  // Low control bits follow the bus; the wake field depends on bus width.
  // In 16-bit mode any write to the field pins it at the fixed code, so
  // the read-and-write-back done by software lands on the 50 ms setting.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      pwr_ff.keep_on <= 1'b0;
      pwr_ff.oc1_off <= 1'b0;
      pwr_ff.oc2_off <= 1'b0;
      pwr_ff.wake <= P_BUS16 ? WAKE_RST_16 : WAKE_RST_32;
    end else if (wr_acc && req.addr == OFS_PWR) begin
      pwr_ff.keep_on <= pwr_merged[PWR_KEEP_ON_BIT];
      pwr_ff.oc1_off <= pwr_merged[PWR_OC1_OFF_BIT];
      pwr_ff.oc2_off <= pwr_merged[PWR_OC2_OFF_BIT];
      if (P_BUS16 && (req.be[2] || req.be[3])) begin
        pwr_ff.wake <= WAKE_FIXED_16;
      end else begin
        pwr_ff.wake <= pwr_merged[PWR_WAKE_LSB +: 16];
      end
    end
  end

  // Wake field handed to the suspend timer outside this bank
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_wake_count <= 16'h0000;
    end else begin
      o_wake_count <= pwr_ff.wake;
    end
  end

  // ********************************************************
  // Port 1 control register
  // ********************************************************
  // One 16-bit store shown in both halves, so bit 23 and bit 7 are the same
  // flag: a one written to bit 23 clears it, and nothing can set it again
  // short of reset. Lower bit 7 writes are ignored on purpose.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      port1_ff <= P1_RST;
    end else if (wr_acc && req.addr == OFS_PORT1) begin
      port1_ff <= (p1_merged[15:0] & P1_WMASK) | (port1_ff & ~P1_WMASK);
      if (req.be[2] && req.wdata[P1_INIT_CLR_BIT]) begin
        port1_ff[P1_INIT_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // Port 1 power only on the full 11b code; init state goes to port 1 alone
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_first_port_power_field_on <= 1'b0;
      o_port1_init_pending <= 1'b1;
    end else begin
      o_first_port_power_field_on <= port1_ff[P1_PWR_LSB +: 2] == P1_PWR_ON;
      o_port1_init_pending <= port1_ff[P1_INIT_FLAG_BIT];
    end
  end

  // ********************************************************
  // Overcurrent detectors
  // ********************************************************
  // Overcurrent pins are asynchronous; two stages before any use
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      oc_meta_ff <= 2'b00;
      oc_sync_ff <= 2'b00;
      oc_prev_ff <= 2'b00;
    end else begin
      oc_meta_ff <= {~i_port2_overcurrent_input_b, ~i_port1_overcurrent_input_b};
      oc_sync_ff <= oc_meta_ff;
      oc_prev_ff <= oc_sync_ff;
    end
  end

  // Detector power drops only in suspend and only when software asked
  assign det_on[0] = !(i_suspend && pwr_ff.oc1_off);
  assign det_on[1] = !(i_suspend && pwr_ff.oc2_off);

  // Power enables to the analog detectors
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_port1_oc_det_pwr <= 1'b1;
      o_port2_oc_det_pwr <= 1'b1;
    end else begin
      o_port1_oc_det_pwr <= det_on[0];
      o_port2_oc_det_pwr <= det_on[1];
    end
  end

  // ********************************************************
  // Suspend clock control
  // ********************************************************
  // Settle time follows the bus width; the 16-bit figure is a parameter
  // so simulation can shorten it
  assign settle_cyc = P_BUS16 ? CNT_W'(P_WAKE_CYC_16) : CNT_W'(WAKE_CYC_32);

  spr_clk_ctl #(
    .P_CNT_W(CNT_W)
  ) u_clk_ctl (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_suspend(i_suspend),
    .i_keep_on(pwr_ff.keep_on),
    .i_settle_cyc(settle_cyc),
    .o_clk_run(clk_run),
    .o_stable(clk_stable)
  );

  // Registered copy of the gate so the port comes from a flop
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_clk_run <= 1'b1;
    end else begin
      o_clk_run <= clk_run;
    end
  end

  // ********************************************************
  // Interrupts
  // ********************************************************
  // Overcurrent counts only while its detector is powered
  assign set_ev[IRQ_CLK_READY] = clk_stable;
  assign set_ev[IRQ_OC1] = det_on[0] && oc_sync_ff[0] && !oc_prev_ff[0];
  assign set_ev[IRQ_OC2] = det_on[1] && oc_sync_ff[1] && !oc_prev_ff[1];
  assign clr_w1c = (wr_acc && req.addr == OFS_IRQ_STAT && req.be[0]) ?
                   req.wdata[IRQ_W-1:0] : '0;

  // Sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~clr_w1c) | set_ev;
    end
  end

  // Mask register, one enables the matching status bit
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      mask_ff <= '0;
    end else if (wr_acc && req.addr == OFS_IRQ_MASK && req.be[0]) begin
      mask_ff <= req.wdata[IRQ_W-1:0];
    end
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat_ff & mask_ff);
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  sequence s_p1_write;
    wr_acc && req.addr == OFS_PORT1;
  endsequence

  sequence s_deep_suspend;
    i_suspend && !pwr_ff.keep_on ##1 i_suspend && !pwr_ff.keep_on;
  endsequence

  property p_first_port_power_field;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_p1_write and (req.be[0] && req.wdata[4:3] == P1_PWR_ON) |=>
      ##1 o_first_port_power_field_on;
  endproperty
  a_first_port_power_field: assert property (p_first_port_power_field) else $error("port 1 power not on");

  property p_first_port_power_field_off;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    port1_ff[P1_PWR_LSB +: 2] != P1_PWR_ON |=> !o_first_port_power_field_on;
  endproperty
  a_first_port_power_field_off: assert property (p_first_port_power_field_off) else $error("port 1 power on");

  property p_init_clear;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_p1_write and (req.be[2] && req.wdata[P1_INIT_CLR_BIT]) |=>
      !port1_ff[P1_INIT_FLAG_BIT] ##1 !o_port1_init_pending;
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("init flag not cleared");

  property p_mirror;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    rd_take && req.addr == OFS_PORT1 |=>
      o_avs_readdata[31:16] == o_avs_readdata[15:0] && !o_avs_waitrequest;
  endproperty
  a_mirror: assert property (p_mirror) else $error("halves differ");

  property p_oc1_off;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_suspend && pwr_ff.oc1_off |=> !o_port1_oc_det_pwr;
  endproperty
  a_oc1_off: assert property (p_oc1_off) else $error("port 1 detector powered");

  property p_oc2_on;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !pwr_ff.oc2_off |=> o_port2_oc_det_pwr;
  endproperty
  a_oc2_on: assert property (p_oc2_on) else $error("port 2 detector off");

  property p_keep_on;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    pwr_ff.keep_on && $past(pwr_ff.keep_on) |-> ##2 o_clk_run;
  endproperty
  a_keep_on: assert property (p_keep_on) else $error("clock stopped");

  property p_stop;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_deep_suspend |-> ##2 !o_clk_run;
  endproperty
  a_stop: assert property (p_stop) else $error("clock not stopped");

  property p_ready;
    @(posedge i_clk_sys) disable iff (!i_rst_b || P_BUS16)
    $rose(clk_run) |-> ##[SETTLE_LO:SETTLE_HI] stat_ff[IRQ_CLK_READY];
  endproperty
  a_ready: assert property (p_ready) else $error("no clocks-stable event");

  property p_wake_default;
    @(posedge i_clk_sys)
    $rose(i_rst_b) |-> pwr_ff.wake == (P_BUS16 ? WAKE_RST_16 : WAKE_RST_32);
  endproperty
  a_wake_default: assert property (p_wake_default) else $error("bad wake default");

  property p_wake_fixed;
    @(posedge i_clk_sys) disable iff (!i_rst_b || !P_BUS16)
    wr_acc && req.addr == OFS_PWR && req.be[2] |=> pwr_ff.wake == WAKE_FIXED_16;
  endproperty
  a_wake_fixed: assert property (p_wake_fixed) else $error("wake not fixed");

  property p_irq;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    set_ev[IRQ_CLK_READY] && mask_ff[IRQ_CLK_READY] |-> ##2 o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule

// [sim/spr_host_model.sv]
// Host software model that drives the register bus
`timescale 1ns/100ps
module spr_host_model
  import spr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output logic [ADDR_W-1:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  logic [31:0] last_rd;

  // Idle bus from time zero
  initial begin
    o_address = '0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = '0;
    o_byteenable = 4'h0;
    last_rd = '0;
  end

  // One access, held until waitrequest is seen low; a leading edge keeps strobes apart
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge i_clk_sys);
    o_address <= a;
    o_writedata <= d;
    o_byteenable <= be;
    o_write <= wr;
    o_read <= !wr;
    @(posedge i_clk_sys);
    while (i_waitrequest) @(posedge i_clk_sys);
    last_rd = i_readdata;
    o_write <= 1'b0;
    o_read <= 1'b0;
  endtask

  // Port 1 start-up write: clears the init flag, powers the port, reserved bits at reset
  task automatic init_port1();
    bus(1'b1, OFS_PORT1, 32'h0080_0018, 4'hf);
  endtask

  // Read the power register and write the same value back
  task automatic pwr_refresh();
    bus(1'b0, OFS_PWR, 32'h0000_0000, 4'hf);
    bus(1'b1, OFS_PWR, last_rd, 4'hf);
  endtask
endmodule

// [sim/test_spr_regs.sv]
// Self-checking bench of the suspend power and port 1 register bank
`timescale 1ns/100ps
module test_spr_regs;
  import spr_pkg::*;
  logic i_clk_sys, i_rst_b, i_suspend, oc1_b, oc2_b;
  logic [ADDR_W-1:0] addr;
  logic rd_s, wr_s, wreq, det1, det2, clk_run, pwr_on, init_pend, irq;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [15:0] wake;
  logic [15:0] wake16;
  logic [15:0] s;
  logic [31:0] exp_q[$];
  int failures, checks_done, cyc, n, seed;

  spr_host_model i_host (.i_clk_sys(i_clk_sys), .i_waitrequest(wreq), .i_readdata(rdata),
    .o_address(addr), .o_read(rd_s), .o_write(wr_s), .o_writedata(wdata),
    .o_byteenable(be));

  spr_regs #(.P_BUS16(1'b0), .P_WAKE_CYC_16(50)) i_dut (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_suspend(i_suspend),
    .i_port1_overcurrent_input_b(oc1_b), .i_port2_overcurrent_input_b(oc2_b),
    .o_port1_oc_det_pwr(det1), .o_port2_oc_det_pwr(det2), .o_clk_run(clk_run),
    .o_first_port_power_field_on(pwr_on), .o_port1_init_pending(init_pend), .o_wake_count(wake),
    .o_irq(irq));

  // 16-bit mode copy on the same bus; only its wake field is watched
  spr_regs #(.P_BUS16(1'b1), .P_WAKE_CYC_16(50)) i_dut16 (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(),
    .o_avs_waitrequest(), .i_suspend(i_suspend),
    .i_port1_overcurrent_input_b(oc1_b), .i_port2_overcurrent_input_b(oc2_b),
    .o_port1_oc_det_pwr(), .o_port2_oc_det_pwr(), .o_clk_run(),
    .o_first_port_power_field_on(), .o_port1_init_pending(), .o_wake_count(wake16), .o_irq());

  // 20 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // ********************************************************
  // Checking and closing
  // ********************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Read data are taken at the edge where waitrequest is low
  always @(posedge i_clk_sys) begin
    if (rd_s && !wreq) begin
      if (exp_q.size() == 0) check(rdata, 32'hdead_beef);
      else check(rdata, exp_q.pop_front());
    end
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_host.bus(1'b0, a, 32'h0000_0000, 4'hf);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] m);
    i_host.bus(1'b1, a, d, m);
  endtask

  // Let the edge's register updates land before looking
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk_sys);
    #1;
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    seed = 32'hcb32_0c36;
    i_rst_b = 1'b0;
    i_suspend = 1'b0;
    oc1_b = 1'b1;
    oc2_b = 1'b1;
    repeat (20) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    tick(3);
    check(init_pend, 1'b1);
    check(wake, 16'h0001);
    check(wake16, 16'h17e8);
    rd(OFS_PORT1, 32'h0096_0096);
    rd(OFS_PWR, 32'h0001_0000);
    rd(10'h000, 32'h0000_0000);
    exp_q.push_back(32'h0001_0000);
    i_host.pwr_refresh();
    rd(OFS_PWR, 32'h0001_0000);
    check(wake16, 16'h1400);
    // A lower-byte write with bit 7 and the power field set must not clear the flag
    wr(OFS_PORT1, 32'h0000_0098, 4'h1);
    rd(OFS_PORT1, 32'h0098_0098);
    tick(2);
    check(pwr_on, 1'b1);
    i_host.init_port1();
    rd(OFS_PORT1, 32'h0018_0018);
    tick(2);
    check(init_pend, 1'b0);
    $display("test port1 init done");
    // Random lower-half values; power only on field 11b
    for (n = 0; n < 6; n++) begin
      // Reserved upper and bits 6:5 kept at their reset zero
      s = 16'($random(seed)) & 16'h009f;
      wr(OFS_PORT1, {16'h0000, s}, 4'h3);
      s = s & 16'hff7f;
      rd(OFS_PORT1, {s, s});
      tick(2);
      check(pwr_on, s[4:3] == 2'b11);
    end
    i_host.init_port1();
    $display("test port1 random done");
    // Clocks kept on, both detectors off in suspend
    wr(OFS_PWR, 32'h0000_0007, 4'h1);
    @(posedge i_clk_sys);
    i_suspend <= 1'b1;
    oc1_b <= 1'b0;
    tick(4);
    check(det1, 1'b0);
    check(det2, 1'b0);
    check(clk_run, 1'b1);
    @(posedge i_clk_sys);
    i_suspend <= 1'b0;
    oc1_b <= 1'b1;
    tick(4);
    check({det1, det2}, 2'b11);
    // Clocks stopped in suspend, event only after the settle time
    wr(OFS_PWR, 32'h0000_0000, 4'h1);
    wr(OFS_IRQ_MASK, 32'h0000_0001, 4'h1);
    @(posedge i_clk_sys);
    i_suspend <= 1'b1;
    tick(5);
    check(clk_run, 1'b0);
    check({det1, det2}, 2'b11);
    @(posedge i_clk_sys);
    i_suspend <= 1'b0;
    tick(100);
    check(irq, 1'b0);
    check(clk_run, 1'b1);
    for (n = 0; n < 400 && irq !== 1'b1; n++) tick(1);
    check(irq, 1'b1);
    rd(OFS_IRQ_STAT, 32'h0000_0001);
    wr(OFS_IRQ_STAT, 32'h0000_0007, 4'h1);
    tick(3);
    check(irq, 1'b0);
    $display("test suspend clocks done");
    // Both overcurrent pins while masked: status only
    @(posedge i_clk_sys);
    oc1_b <= 1'b0;
    oc2_b <= 1'b0;
    tick(8);
    rd(OFS_IRQ_STAT, 32'h0000_0006);
    oc1_b <= 1'b1;
    oc2_b <= 1'b1;
    tick(1);
    check(irq, 1'b0);
    $display("test overcurrent done");
    tick(4);
    tally_and_finish();
  end
endmodule
